// file: oscp_pkg.sv
// Function
// - Step key cycles 0.01, 0.1, 1 steps.
// - While editing, light indicator, blink once changed, keep old setpoint.
// - One key press changes by one step.
// - Held key repeats fast, step ignored.
// - Confirm with no bus write in that cycle applies edited value in one jump.
// - Repeated confirm alternates voltage and current.
// - Local output key toggles output.
// - Remote or locked ignores output key.
// - Trigger mode output switches output.
// - Trigger-held off rejects enable, flags error.
// - Output lamp follows output; modes dark off.
// - Overtemperature lights lamp, refuses enable.
// - Recall option re-enables after cooling.
// - Setpoint above soft limit rejected, error.
// - Soft limit below setpoint refused.
// - Effective setpoint is digital plus analog.
// - Soft limit writes act immediately.
// - Overvoltage kills output fast, discharges 350 ms.
// - Overvoltage sets event, status follows level.
// - After overvoltage, normal requests re-enable.
// - Overcurrent enabled: regulation starts off-delay.
// - Leaving regulation cancels, restart from zero.
// - Overcurrent disabled only limits current.
package oscp_pkg;
    localparam int CLK_MHZ     = 100;
    localparam int TICK_US     = 10000;
    localparam int TICK_CYC    = TICK_US * CLK_MHZ;
    localparam int TICK_W      = 20;
    localparam int DISCH_MS    = 350;
    localparam int HOLD_MS     = 500;
    localparam int REP_MS      = 50;
    localparam int ERR_MS      = 1000;
    localparam int BLINK_MS    = 250;
    localparam int CNT_W       = 8;
    localparam logic [7:0] DISCH_TK = 8'(DISCH_MS * 1000 / TICK_US);
    localparam logic [7:0] HOLD_TK  = 8'(HOLD_MS * 1000 / TICK_US);
    localparam logic [7:0] REP_TK   = 8'(REP_MS * 1000 / TICK_US);
    localparam logic [7:0] ERR_TK   = 8'(ERR_MS * 1000 / TICK_US);
    localparam logic [7:0] BLINK_TK = 8'(BLINK_MS * 1000 / TICK_US);
    localparam int SP_W        = 16;
    localparam logic [15:0] STEP_FINE = 16'h0001;
    localparam logic [15:0] STEP_MID  = 16'h000a;
    localparam logic [15:0] STEP_CRS  = 16'h0064;
    localparam logic [5:0] A_CTRL   = 6'h00;
    localparam logic [5:0] A_CMD    = 6'h04;
    localparam logic [5:0] A_VSET   = 6'h08;
    localparam logic [5:0] A_ISET   = 6'h0c;
    localparam logic [5:0] A_VLIM   = 6'h10;
    localparam logic [5:0] A_ILIM   = 6'h14;
    localparam logic [5:0] A_OVTH   = 6'h18;
    localparam logic [5:0] A_DELAY  = 6'h1c;
    localparam logic [5:0] A_STAT   = 6'h20;
    localparam logic [5:0] A_EVA    = 6'h24;
    localparam logic [5:0] A_EVB    = 6'h28;
    localparam int CTL_REMOTE  = 0;
    localparam int CTL_LOCK    = 1;
    localparam int CTL_OCP     = 2;
    localparam int CTL_RECALL  = 3;
    localparam int CTL_TRGOUT  = 4;
    localparam int CMD_ON      = 0;
    localparam int CMD_OFF     = 1;
    localparam int EVA_OV      = 4;
    localparam int EVB_SPERR   = 0;
    localparam int EVB_LIMERR  = 1;
    localparam int EVB_ONERR   = 4;
    localparam logic [4:0]  CTRL_RST  = 5'h00;
    localparam logic [15:0] SP_RST    = 16'h0000;
    localparam logic [15:0] LIM_RST   = 16'hffff;
    localparam logic [15:0] OVTH_RST  = 16'hffff;
    localparam logic [15:0] DELAY_RST = 16'h0000;
    typedef enum logic [1:0] {
        OUT_OFF   = 2'b00,
        OUT_ON    = 2'b01,
        OUT_DISCH = 2'b10
    } oscp_out_t;
endpackage

// file: oscp_key_if.sv
`timescale 1ns/1ps
interface oscp_key_if;
    logic tick;
    logic up;
    logic dn;
    logic inc;
    logic dec;
    logic fast;
    modport ctl (output tick, output up, output dn,
                 input inc, input dec, input fast);
    modport rep (input tick, input up, input dn,
                 output inc, output dec, output fast);
endinterface

// file: oscp_keyrep.sv
`timescale 1ns/1ps
module oscp_keyrep
    import oscp_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  rst,
    oscp_key_if.rep    kp
);
    typedef struct packed {
        logic [1:0]             q;
        logic [1:0][CNT_W-1:0]  cnt;
        logic [1:0]             p;
        logic                   f;
    } oscp_kr_t;

    oscp_kr_t s;
    oscp_kr_t n;
    logic [1:0] lvl;

    assign lvl = {kp.dn, kp.up};

    always_comb
    begin
        n     = s;
        n.q   = lvl;
        n.p   = 2'b00;
        n.f   = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            if (lvl[k] && !s.q[k])
            begin
                n.p[k]   = 1'b1;
                n.cnt[k] = '0;
            end
            else if (lvl[k] && kp.tick)
            begin
                // Repeats use a fixed rate and the finest step.
                if (s.cnt[k] == HOLD_TK - 8'h01)
                begin
                    n.p[k]   = 1'b1;
                    n.f      = 1'b1;
                    n.cnt[k] = HOLD_TK - REP_TK;
                end
                else
                begin
                    n.cnt[k] = s.cnt[k] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    assign kp.inc  = s.p[0];
    assign kp.dec  = s.p[1] & ~s.p[0];
    assign kp.fast = s.f;
endmodule // oscp_keyrep

// file: oscp_top.sv
`timescale 1ns/1ps
module oscp_top
    import oscp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        key_step,
    input  wire logic        key_up,
    input  wire logic        key_down,
    input  wire logic        key_enter,
    input  wire logic        key_cancel,
    input  wire logic        key_output,
    input  wire logic        trig_in,
    input  wire logic        overtemp,
    input  wire logic        cc_mode,
    input  wire logic [15:0] vout_meas,
    input  wire logic [15:0] analog_vset,
    input  wire logic [15:0] analog_iset,
    output logic [16:0]      vset_eff,
    output logic [16:0]      iset_eff,
    output logic             output_en,
    output logic             converter_en,
    output logic             discharge_en,
    output logic             led_output,
    output logic             led_cv,
    output logic             led_cc,
    output logic             led_set,
    output logic             led_edit_i,
    output logic             led_ov,
    output logic             led_oc,
    output logic             led_ot,
    output logic             err25_show,
    output logic [15:0]      disp_value
);
    typedef struct packed {
        logic              ack;
        logic [31:0]       rdata;
        logic [4:0]        ctrl;
        logic [15:0]       vset;
        logic [15:0]       iset;
        logic [15:0]       vlim;
        logic [15:0]       ilim;
        logic [15:0]       ovth;
        logic [15:0]       dly;
        logic [15:0]       pre_v;
        logic [15:0]       pre_i;
        logic              sel_i;
        logic              edit;
        logic              dirty;
        logic [1:0]        step;
        oscp_out_t         ost;
        logic              ov_led;
        logic              oc_led;
        logic              ot_rest;
        logic [7:0]        ev_a;
        logic [7:0]        ev_b;
        logic [7:0]        dis_cnt;
        logic [15:0]       oc_cnt;
        logic [7:0]        err_cnt;
        logic [7:0]        blk_cnt;
        logic              blink;
        logic [TICK_W-1:0] tick_cnt;
        logic [4:0]        kq;
        logic [16:0]       eff_v;
        logic [16:0]       eff_i;
    } oscp_st_t;

    oscp_st_t s;
    oscp_st_t n;

    oscp_key_if kp ();

    logic        tick;
    logic        req;
    logic        wr;
    logic        e_out;
    logic        e_ent;
    logic        e_stp;
    logic        e_esc;
    logic        t_rise;
    logic        local_ok;
    logic        trig_blk;
    logic        ov_live;
    logic        oc_exp;
    logic        bus_on;
    logic        bus_off;
    logic        on_req;
    logic        off_req;
    logic        key_on;
    logic [15:0] wd16;
    logic [15:0] amt;
    logic [15:0] cur;

    function automatic logic [15:0] be16(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
        be16 = old;
        if (be[0])
            be16[7:0] = wd[7:0];
        if (be[1])
            be16[15:8] = wd[15:8];
    endfunction

    function automatic logic [15:0] stepval(input logic [1:0] idx);
        case (idx)
            2'd1:    stepval = STEP_MID;
            2'd2:    stepval = STEP_CRS;
            default: stepval = STEP_FINE;
        endcase
    endfunction

    oscp_keyrep u_rep (
        .mclk (mclk),
        .rst  (rst),
        .kp   (kp.rep)
    );

    assign kp.tick = tick;
    assign kp.up   = key_up & s.edit;
    assign kp.dn   = key_down & s.edit;

    always_comb
    begin
        n          = s;
        tick       = (s.tick_cnt == TICK_W'(TICK_CYCLES - 1));
        n.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
        n.kq       = {key_output, key_enter, key_step, key_cancel, trig_in};
        e_out      = key_output & ~s.kq[4];
        e_ent      = key_enter & ~s.kq[3];
        e_stp      = key_step & ~s.kq[2];
        e_esc      = key_cancel & ~s.kq[1];
        t_rise     = trig_in & ~s.kq[0];
        req        = avs_read | avs_write;
        n.ack      = req & ~s.ack;
        wr         = avs_write & s.ack;
        wd16       = 16'h0000;
        bus_on     = 1'b0;
        bus_off    = 1'b0;
        ov_live    = (vout_meas > s.ovth);
        trig_blk   = s.ctrl[CTL_TRGOUT] & ~trig_in;
        local_ok   = ~s.ctrl[CTL_REMOTE] & ~s.ctrl[CTL_LOCK];
        // A register read is captured while waitrequest is high.
        if (avs_read && !s.ack)
        begin
            case (avs_address)
                A_CTRL:  n.rdata = {27'h0, s.ctrl};
                A_VSET:  n.rdata = {16'h0, s.vset};
                A_ISET:  n.rdata = {16'h0, s.iset};
                A_VLIM:  n.rdata = {16'h0, s.vlim};
                A_ILIM:  n.rdata = {16'h0, s.ilim};
                A_OVTH:  n.rdata = {16'h0, s.ovth};
                A_DELAY: n.rdata = {16'h0, s.dly};
                A_STAT:  n.rdata = {24'h0, s.sel_i, s.edit, cc_mode,
                                    ov_live, s.ov_led, s.oc_led, overtemp,
                                    s.ost == OUT_ON};
                A_EVA:   n.rdata = {24'h0, s.ev_a};
                A_EVB:   n.rdata = {24'h0, s.ev_b};
                default: n.rdata = 32'h0;
            endcase
        end
        if (wr)
        begin
            case (avs_address)
                A_CTRL:
                begin
                    wd16   = be16({11'h0, s.ctrl}, avs_writedata,
                                  avs_byteenable);
                    n.ctrl = wd16[4:0];
                end
                A_CMD:
                begin
                    bus_on  = avs_byteenable[0] & avs_writedata[CMD_ON];
                    bus_off = avs_byteenable[0] & avs_writedata[CMD_OFF];
                end
                A_VSET:
                begin
                    wd16 = be16(s.vset, avs_writedata, avs_byteenable);
                    if (wd16 > s.vlim)
                        n.ev_b[EVB_SPERR] = 1'b1;
                    else
                        n.vset = wd16;
                end
                A_ISET:
                begin
                    wd16 = be16(s.iset, avs_writedata, avs_byteenable);
                    if (wd16 > s.ilim)
                        n.ev_b[EVB_SPERR] = 1'b1;
                    else
                        n.iset = wd16;
                end
                A_VLIM:
                begin
                    wd16 = be16(s.vlim, avs_writedata, avs_byteenable);
                    if (wd16 < s.vset)
                        n.ev_b[EVB_LIMERR] = 1'b1;
                    else
                        n.vlim = wd16;
                end
                A_ILIM:
                begin
                    wd16 = be16(s.ilim, avs_writedata, avs_byteenable);
                    if (wd16 < s.iset)
                        n.ev_b[EVB_LIMERR] = 1'b1;
                    else
                        n.ilim = wd16;
                end
                A_OVTH:  n.ovth = be16(s.ovth, avs_writedata, avs_byteenable);
                A_DELAY: n.dly = be16(s.dly, avs_writedata, avs_byteenable);
                // Write-one-to-clear; hardware sets below win the cycle.
                A_EVA:   n.ev_a = s.ev_a & ~avs_writedata[7:0];
                A_EVB:   n.ev_b = n.ev_b & ~avs_writedata[7:0];
                default: ;
            endcase
        end

        // Pre-selection editing; the applied setpoint stays until confirm.
        cur = s.sel_i ? s.pre_i : s.pre_v;
        amt = kp.fast ? STEP_FINE : stepval(s.step);
        if (e_stp)
            n.step = (s.step == 2'd2) ? 2'd0 : s.step + 2'd1;
        if (s.edit && e_esc)
            n.edit = 1'b0;
        else if (e_ent && !s.edit)
        begin
            n.edit  = 1'b1;
            n.sel_i = 1'b0;
            n.dirty = 1'b0;
            n.pre_v = s.vset;
            n.pre_i = s.iset;
        end
        else if (e_ent)
        begin
            if (s.dirty && !s.sel_i && !wr)
            begin
                if (s.pre_v > s.vlim)
                    n.ev_b[EVB_SPERR] = 1'b1;
                else
                    n.vset = s.pre_v;
            end
            else if (s.dirty && !wr)
            begin
                if (s.pre_i > s.ilim)
                    n.ev_b[EVB_SPERR] = 1'b1;
                else
                    n.iset = s.pre_i;
            end
            n.dirty = 1'b0;
            n.sel_i = ~s.sel_i;
            n.pre_v = s.vset;
            n.pre_i = s.iset;
        end
        else if (s.edit && (kp.inc || kp.dec))
        begin
            // A step that would wrap is dropped rather than clipped.
            if (kp.inc && (cur <= 16'hffff - amt))
                cur = cur + amt;
            else if (kp.dec && (cur >= amt))
                cur = cur - amt;
            if (s.sel_i)
                n.pre_i = cur;
            else
                n.pre_v = cur;
            n.dirty = 1'b1;
        end

        // Overcurrent off-delay in hundredths of a second.
        oc_exp = 1'b0;
        if (s.ost == OUT_ON && s.ctrl[CTL_OCP] && cc_mode)
        begin
            oc_exp = (s.oc_cnt >= s.dly);
            if (tick && !oc_exp)
                n.oc_cnt = s.oc_cnt + 16'h0001;
        end
        else
            n.oc_cnt = 16'h0000;

        key_on  = e_out & local_ok & (s.ost != OUT_ON);
        on_req  = key_on | bus_on
                | (t_rise & s.ctrl[CTL_TRGOUT]);
        off_req = (e_out & local_ok) | bus_off | trig_blk;
        if (s.err_cnt != 8'h00 && tick)
            n.err_cnt = s.err_cnt - 8'h01;
        case (s.ost)
            OUT_OFF:
            begin
                if (s.ot_rest && !overtemp && !trig_blk && !ov_live)
                begin
                    n.ost     = OUT_ON;
                    n.ot_rest = 1'b0;
                end
                else if (on_req && trig_blk)
                begin
                    n.ev_b[EVB_ONERR] = 1'b1;
                    if (key_on)
                        n.err_cnt = ERR_TK;
                end
                else if (on_req && !overtemp && !ov_live)
                begin
                    n.ost    = OUT_ON;
                    n.ov_led = 1'b0;
                    n.oc_led = 1'b0;
                end
            end
            OUT_ON:
            begin
                if (ov_live)
                begin
                    n.ost          = OUT_DISCH;
                    n.dis_cnt      = DISCH_TK;
                    n.ev_a[EVA_OV] = 1'b1;
                    n.ov_led       = 1'b1;
                end
                else if (overtemp)
                begin
                    n.ost     = OUT_OFF;
                    n.ot_rest = s.ctrl[CTL_RECALL];
                end
                else if (oc_exp)
                begin
                    n.ost    = OUT_OFF;
                    n.oc_led = 1'b1;
                end
                else if (off_req)
                    n.ost = OUT_OFF;
            end
            OUT_DISCH:
            begin
                if (tick)
                    n.dis_cnt = s.dis_cnt - 8'h01;
                if (s.dis_cnt == 8'h00)
                    n.ost = OUT_OFF;
            end
            default: n.ost = OUT_OFF;
        endcase

        if (tick)
        begin
            n.blk_cnt = (s.blk_cnt == 8'h00) ? BLINK_TK : s.blk_cnt - 8'h01;
            if (s.blk_cnt == 8'h00)
                n.blink = ~s.blink;
        end
        n.eff_v = {1'b0, s.vset} + {1'b0, analog_vset};
        n.eff_i = {1'b0, s.iset} + {1'b0, analog_iset};
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s      <= '0;
            s.ctrl <= CTRL_RST;
            s.vset <= SP_RST;
            s.iset <= SP_RST;
            s.vlim <= LIM_RST;
            s.ilim <= LIM_RST;
            s.ovth <= OVTH_RST;
            s.dly  <= DELAY_RST;
            s.ost  <= OUT_OFF;
        end
        else
            s <= n;
    end

    assign avs_waitrequest = req & ~s.ack;
    assign avs_readdata    = s.rdata;
    assign vset_eff        = s.eff_v;
    assign iset_eff        = s.eff_i;
    assign output_en       = (s.ost == OUT_ON);
    assign converter_en    = (s.ost == OUT_ON);
    assign discharge_en    = (s.ost == OUT_DISCH);
    assign led_output      = output_en;
    assign led_cv          = output_en & ~cc_mode;
    assign led_cc          = output_en & cc_mode;
    assign led_set         = s.edit & (~s.dirty | s.blink);
    assign led_edit_i      = s.sel_i;
    assign led_ov          = s.ov_led;
    assign led_oc          = s.oc_led;
    assign led_ot          = overtemp;
    assign err25_show      = (s.err_cnt != 8'h00);
    assign disp_value      = s.sel_i ? s.pre_i : s.pre_v;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_ov_trip_off: assert property (
        (s.ost == OUT_ON && ov_live) |=> discharge_en && !converter_en
            ##1 !output_en)
        else $error("overvoltage did not stop the output");
    a_ov_event_set: assert property (
        (s.ost == OUT_ON && ov_live) |=> s.ev_a[EVA_OV] && led_ov)
        else $error("overvoltage event flag not set");
    a_locked_key: assert property (
        (s.ost == OUT_OFF && e_out && !local_ok && !bus_on && !t_rise
            && !s.ot_rest) |=> !output_en)
        else $error("output key acted while locked");
    a_trig_reject: assert property (
        (s.ost == OUT_OFF && on_req && trig_blk && !s.ot_rest)
            |=> !output_en && s.ev_b[EVB_ONERR])
        else $error("enable accepted while trigger holds off");
    a_ot_refuse: assert property (
        overtemp |=> !output_en)
        else $error("output on during overtemperature");
    a_soft_limits: assert property (
        s.vset <= s.vlim && s.iset <= s.ilim)
        else $error("setpoint above soft limit");
    a_oc_cancel: assert property (
        !cc_mode |=> s.oc_cnt == 16'h0000)
        else $error("off-delay not cleared");
    a_ocp_disabled: assert property (
        !s.ctrl[CTL_OCP] |-> !oc_exp ##1 !(s.oc_led && $rose(s.oc_led)))
        else $error("overcurrent trip with protection off");
    a_confirm_apply: assert property (
        (s.edit && e_ent && !e_esc && s.dirty && !s.sel_i && !wr
            && s.pre_v <= s.vlim) |=> s.vset == $past(s.pre_v) && s.sel_i)
        else $error("confirm did not apply voltage");
    a_mode_leds: assert property (
        (s.ost != OUT_ON) |-> ##1 (!led_cv && !led_cc) || output_en)
        else $error("mode lamps lit with output off");
endmodule // oscp_top

// file: oscp_stage_model.sv
`timescale 1ns/1ps
module oscp_stage_model
    import oscp_pkg::*;
(
    mclk,
    output_en,
    vset_eff,
    load_heavy,
    v_spike,
    cc_mode,
    vout_meas
);
    input  wire logic        mclk;
    input  wire logic        output_en;
    input  wire logic [16:0] vset_eff;
    input  wire logic        load_heavy;
    input  wire logic [15:0] v_spike;
    output logic             cc_mode;
    output logic [15:0]      vout_meas;
    // A forced terminal voltage overrides the stage and outlasts
    // shutdown, so the live overvoltage flag can still be seen.
    always_ff @(posedge mclk)
    begin
        cc_mode   <= output_en & load_heavy;
        vout_meas <= (v_spike != 16'h0000) ? v_spike
                   : (output_en ? vset_eff[15:0] : 16'h0000);
    end
endmodule // oscp_stage_model

// file: test_output_setpoint_and_protection_ctrl.sv
`timescale 1ns/1ps
module test_output_setpoint_and_protection_ctrl;
    import oscp_pkg::*;
    localparam int TK = 10;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  adr = 6'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic [31:0] got;
    logic        wrq;
    logic [5:0]  key = 6'h00;
    logic        trig = 1'b1;
    logic        heavy = 1'b0;
    logic        ot = 1'b0;
    logic [15:0] spike = 16'h0000;
    logic [15:0] an_v = 16'h0000;
    logic [15:0] an_i = 16'h0000;
    logic        cc;
    logic [15:0] vout;
    logic [16:0] v_eff;
    logic [16:0] i_eff;
    logic [15:0] disp;
    logic [11:0] led;
    logic [31:0] seed = 32'h48b0dd44;
    logic [15:0] lim;
    logic [15:0] vs;
    logic [5:0]  la;
    logic [5:0]  sa;
    int          seq[7] = '{1, 0, 1, 0, 1, 0, 2};
    int          errors = 0;
    int          n_checks = 0;
    int          cyc = 0;

    oscp_top #(.TICK_CYCLES(TK)) i_dut (
        .mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
        .avs_readdata(rdat), .avs_waitrequest(wrq), .key_step(key[0]),
        .key_up(key[1]), .key_down(key[2]), .key_enter(key[3]),
        .key_cancel(key[4]), .key_output(key[5]), .trig_in(trig),
        .overtemp(ot), .cc_mode(cc), .vout_meas(vout),
        .analog_vset(an_v), .analog_iset(an_i), .vset_eff(v_eff),
        .iset_eff(i_eff), .output_en(led[0]), .converter_en(led[1]),
        .discharge_en(led[2]), .led_output(led[3]), .led_cv(led[4]),
        .led_cc(led[5]), .led_set(led[6]), .led_edit_i(led[7]),
        .led_ov(led[8]), .led_oc(led[9]), .led_ot(led[10]),
        .err25_show(led[11]), .disp_value(disp));
    oscp_stage_model i_stage (.mclk(mclk), .output_en(led[0]),
        .vset_eff(v_eff), .load_heavy(heavy), .v_spike(spike),
        .cc_mode(cc), .vout_meas(vout));

    always #5 mclk = ~mclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [31:0] eff(input logic [15:0] a,
                                        input logic [15:0] b);
        return 32'({1'b0, a} + {1'b0, b});
    endfunction
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tdone();
        $display("test done at %0t, mismatches %0d", $time, errors);
    endtask
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [15:0] d);
        @(posedge mclk);
        adr <= a;
        wd <= {16'h0, d};
        {rd, wr} <= {~w, w};
        do @(posedge mclk); while (wrq !== 1'b0);
        got = rdat;
        {rd, wr} <= 2'b00;
    endtask
    task automatic press(input int k);
        @(posedge mclk);
        key <= 6'(1 << k);
        repeat (3) @(posedge mclk);
        key <= 6'h00;
        repeat (4) @(posedge mclk);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // A hang anywhere ends the run through the same verdict.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            print_verdict();
        end
    end

    initial
    begin
        wt(4);
        rst <= 1'b0;
        bus(0, A_VLIM, 16'h0);
        check(got, 32'hffff);
        press(5);
        check(32'(led[5:0]), 32'h1b);
        press(5);
        check(32'(led[5:0]), 32'h0);
        for (int m = 0; m < 2; m++)
        begin
            bus(1, A_CTRL, 16'(1 << (m ? CTL_LOCK : CTL_REMOTE)));
            press(5);
            check(32'(led[0]), 32'h0);
        end
        bus(1, A_CTRL, 16'h0);
        tdone();
        for (int q = 0; q < 2; q++)
        begin
            seed = xs(seed);
            lim = {1'b0, seed[14:0]} | 16'h1000;
            an_v <= {4'h0, seed[27:16]};
            an_i <= {4'h0, seed[30:19]};
            la = q ? A_ILIM : A_VLIM;
            sa = q ? A_ISET : A_VSET;
            bus(1, la, lim);
            bus(1, sa, lim + 16'h1);
            bus(0, sa, 16'h0);
            check(got, 32'h0);
            bus(1, sa, lim);
            bus(1, la, lim - 16'h1);
            bus(0, la, 16'h0);
            check(got, 32'(lim));
            bus(0, A_EVB, 16'h0);
            check(got, 32'h3);
            bus(1, A_EVB, 16'h3);
            bus(1, la, 16'hffff);
            bus(0, la, 16'h0);
            check(got, 32'hffff);
            check(32'(q ? i_eff : v_eff), eff(lim, q ? an_i : an_v));
            if (q == 0)
                vs = lim;
        end
        tdone();
        press(3);
        check(32'(disp), 32'(vs));
        foreach (seq[i])
            press(seq[i]);
        check(32'(disp), 32'(vs + 16'h006e));
        check(32'(v_eff), eff(vs, an_v));
        press(3);
        check(32'(v_eff), eff(vs + 16'h006e, an_v));
        check(32'(led[7]), 32'h1);
        press(0);
        press(0);
        key <= 6'h02;
        wt(62 * TK);
        key <= 6'h00;
        wt(4);
        check(32'(disp), 32'(lim + 16'h0067));
        press(4);
        tdone();
        bus(1, A_OVTH, v_eff[15:0] + 16'h10);
        press(5);
        spike <= v_eff[15:0] + 16'h0020;
        wt(3);
        check(32'({led[8], led[5:0]}), 32'h44);
        bus(0, A_STAT, 16'h0);
        check(32'(got[4]), 32'h1);
        bus(0, A_EVA, 16'h0);
        check(got, 32'h1 << EVA_OV);
        spike <= 16'h0000;
        bus(0, A_STAT, 16'h0);
        check(32'(got[4]), 32'h0);
        wt(30 * TK);
        check(32'(led[2]), 32'h1);
        wt(10 * TK);
        check(32'(led[2]), 32'h0);
        press(5);
        check(32'({led[8], led[0]}), 32'h1);
        tdone();
        bus(1, A_CTRL, 16'(1 << CTL_TRGOUT));
        trig <= 1'b0;
        wt(3);
        check(32'(led[0]), 32'h0);
        press(5);
        check(32'({led[11], led[0]}), 32'h2);
        bus(1, A_CMD, 16'(1 << CMD_ON));
        bus(0, A_EVB, 16'h0);
        check(32'({got[EVB_ONERR], led[0]}), 32'h2);
        trig <= 1'b1;
        wt(3);
        check(32'(led[0]), 32'h1);
        bus(1, A_CTRL, 16'(1 << CTL_RECALL));
        ot <= 1'b1;
        wt(3);
        check(32'({led[10], led[0]}), 32'h2);
        press(5);
        check(32'(led[0]), 32'h0);
        ot <= 1'b0;
        wt(3);
        check(32'(led[0]), 32'h1);
        bus(1, A_CTRL, 16'h0);
        tdone();
        heavy <= 1'b1;
        wt(20 * TK);
        check(32'({led[5], led[0]}), 32'h3);
        heavy <= 1'b0;
        bus(1, A_DELAY, 16'h5);
        bus(1, A_CTRL, 16'(1 << CTL_OCP));
        heavy <= 1'b1;
        wt(3 * TK);
        heavy <= 1'b0;
        wt(2);
        heavy <= 1'b1;
        wt(4 * TK);
        check(32'(led[0]), 32'h1);
        wt(4 * TK);
        check(32'({led[9], led[0]}), 32'h2);
        tdone();
        print_verdict();
    end
endmodule // test_output_setpoint_and_protection_ctrl
